/* logic/cmn_bus_master.sv */
// single outstanding read or write cycle on the system bus
`timescale 1ns/1ps
module cmn_bus_master (
  // clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       arst_n_in,
  // request side
  input  wire logic                       req_valid_in,
  input  wire cmn_pkg::cmn_bus_req_s      req_in,
  output cmn_pkg::cmn_bus_rsp_s           rsp_out,
  // system bus
  output logic [cmn_pkg::ADDR_W-1:0]      bus_addr_out,
  output logic [cmn_pkg::DATA_W-1:0]      bus_wdata_out,
  output logic                            bus_rd_out,
  output logic                            bus_wr_out,
  input  wire logic [cmn_pkg::DATA_W-1:0] bus_rdata_in,
  input  wire logic                       bus_ack_in
);
  import cmn_pkg::*;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    cmn_bus_rsp_s      rsp;
  } cmn_bm_st_s;

  cmn_bm_st_s bq, bd;

  // strobe holds until the slave acknowledges, answer is a one-cycle pulse
  always_comb begin
    bd          = bq;
    bd.rsp.done = 1'b0;
    if (!bq.rd && !bq.wr && req_valid_in) begin
      bd.rd    = !req_in.write;
      bd.wr    = req_in.write;
      bd.addr  = req_in.addr;
      bd.wdata = req_in.data;
    end else if ((bq.rd || bq.wr) && bus_ack_in) begin
      bd.rd       = 1'b0;
      bd.wr       = 1'b0;
      bd.rsp.done = 1'b1;
      bd.rsp.data = bus_rdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bq <= '0;
    end else begin
      bq <= bd;
    end
  end

  assign bus_rd_out    = bq.rd;
  assign bus_wr_out    = bq.wr;
  assign bus_addr_out  = bq.addr;
  assign bus_wdata_out = bq.wdata;
  assign rsp_out       = bq.rsp;

  a_bus_one_strobe: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    !(bq.rd && bq.wr))
    else $error("read and write strobes together");
  a_bus_addr_hold: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (bq.rd || bq.wr) && !bus_ack_in |=> $stable(bq.addr) && (bq.rd || bq.wr))
    else $error("bus cycle dropped before acknowledge");
endmodule : cmn_bus_master

/* logic/cmn_console_monitor.sv */
// console monitor entry, announce and polled character sequencer
//
// How it works
// - enter on powerup, break, halt, halt line, timeout
// - on entry read receive buffer, discard character
// - print six digit counter after cr lf
// - data timeout entry prints question mark instead
// - then cr lf and at-sign prompt
// - poll receive status until done bit set
// - then read low byte of receive buffer
// - poll transmit status until done bit set
// - then read and write transmit buffer
// - ignore bit 7, echo raw, own chars clear
// - unaccepted characters answered with question mark
`timescale 1ns/1ps
module cmn_console_monitor #(
  parameter int FIFO_DEPTH = cmn_pkg::CMD_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       arst_n_in,
  // entry events and processor state
  input  wire logic                       break_in,
  input  wire logic                       halt_instr_in,
  input  wire logic                       bus_halt_request_in,
  input  wire logic                       nxm_in,
  input  wire logic                       nxm_fetch_in,
  input  wire logic [15:0]                pc_in,
  input  wire logic                       exit_in,
  // system bus
  output logic [cmn_pkg::ADDR_W-1:0]      bus_addr_out,
  output logic [cmn_pkg::DATA_W-1:0]      bus_wdata_out,
  output logic                            bus_rd_out,
  output logic                            bus_wr_out,
  input  wire logic [cmn_pkg::DATA_W-1:0] bus_rdata_in,
  input  wire logic                       bus_ack_in,
  // accepted command characters
  output logic [cmn_pkg::CHAR_W-1:0]      cmd_char_out,
  output logic                            cmd_valid_out,
  input  wire logic                       cmd_ready_in,
  // status
  output logic                            monitor_active_out
);
  import cmn_pkg::*;

  typedef struct packed {
    cmn_state_e        state;
    cmn_step_e         step;
    logic              issued;
    logic              entered;
    logic              active;
    logic              pc_mode;
    logic [15:0]       pc;
    logic [CHAR_W-1:0] rx_char;
    logic              halt_sync1;
    logic              halt_sync2;
  } cmn_mon_st_s;

  cmn_mon_st_s  sq, sd;
  cmn_bus_req_s req;
  cmn_bus_rsp_s rsp;
  logic         req_valid;
  logic         push;
  logic         fifo_ready;
  logic         entry_evt;
  logic         data_timeout;
  logic         status_done;
  logic         tx_fin;

  // octal digit for each digit step, top digit carries a single bit
  function automatic logic [2:0] pc_digit(input cmn_step_e s, input logic [15:0] pc);
    logic [2:0] d;
    d = 3'h0;
    unique case (s)
      ST_DIG0: d = {2'b00, pc[15]};
      ST_DIG1: d = pc[14:12];
      ST_DIG2: d = pc[11:9];
      ST_DIG3: d = pc[8:6];
      ST_DIG4: d = pc[5:3];
      ST_DIG5: d = pc[2:0];
      default: d = 3'h0;
    endcase
    return d;
  endfunction : pc_digit

  // character sent for the current step
  function automatic logic [CHAR_W-1:0] step_char(input cmn_step_e s,
                                                  input logic [15:0] pc,
                                                  input logic [CHAR_W-1:0] rx);
    logic [CHAR_W-1:0] c;
    c = CH_QUERY;
    unique case (s)
      ST_CR1, ST_CR2: c = CH_CR;
      ST_LF1, ST_LF2: c = CH_LF;
      ST_PROMPT:      c = CH_PROMPT;
      ST_ECHO:        c = rx;
      ST_QUERY:       c = CH_QUERY;
      default:        c = CH_ZERO | {5'h00, pc_digit(s, pc)};
    endcase
    return c;
  endfunction : step_char

  // characters the monitor accepts; parity bit stripped first
  function automatic logic char_ok(input logic [CHAR_W-1:0] raw);
    logic [CHAR_W-1:0] c;
    c = raw & CH_MASK7;
    return ((c >= CH_ZERO) && (c <= CH_SEVEN)) || (c == CH_UP_R) || (c == CH_UP_S) ||
           (c == CH_SLASH) || (c == CH_UP_G) || (c == CH_UP_P) || (c == CH_UP_X) ||
           (c == CH_UP_D) || (c == CH_CR) || (c == CH_LF);
  endfunction : char_ok

  // entry events; the halt line is a bus pin and is synchronised first
  assign entry_evt    = !sq.entered || break_in || halt_instr_in ||
                        sq.halt_sync2 || nxm_in;
  assign data_timeout = nxm_in && !nxm_fetch_in;
  assign status_done  = rsp.data[DONE_BIT];
  assign tx_fin       = (sq.state == MS_TX_WRITE) && rsp.done;

  // sequencer; one bus cycle outstanding at a time keeps the ordering trivial
  always_comb begin
    sd            = sq;
    req           = '0;
    push          = 1'b0;
    sd.halt_sync1 = bus_halt_request_in;
    sd.halt_sync2 = sq.halt_sync1;
    unique case (sq.state)
      MS_RUN: begin
        if (entry_evt) begin
          sd.state   = MS_FLUSH;
          sd.entered = 1'b1;
          sd.active  = 1'b1;
          sd.pc      = pc_in;
          sd.pc_mode = !data_timeout;
        end
      end
      MS_FLUSH: begin
        req.addr = RX_BUFFER_ADDR;
        if (rsp.done) begin
          sd.state = MS_TX_POLL;
          sd.step  = ST_CR1;
        end
      end
      MS_TX_POLL: begin
        req.addr = TX_STATUS_ADDR;
        if (rsp.done && status_done) begin
          sd.state = MS_TX_READ;
        end
      end
      MS_TX_READ: begin
        req.addr = TX_BUFFER_ADDR;
        if (rsp.done) begin
          sd.state = MS_TX_WRITE;
        end
      end
      MS_TX_WRITE: begin
        req.addr  = TX_BUFFER_ADDR;
        req.write = 1'b1;
        req.data  = {8'h00, step_char(sq.step, sq.pc, sq.rx_char)};
        if (rsp.done) begin
          sd.state = MS_TX_POLL;
          unique case (sq.step)
            ST_CR1:    sd.step = ST_LF1;
            ST_LF1:    sd.step = sq.pc_mode ? ST_DIG0 : ST_QUERY;
            ST_DIG0:   sd.step = ST_DIG1;
            ST_DIG1:   sd.step = ST_DIG2;
            ST_DIG2:   sd.step = ST_DIG3;
            ST_DIG3:   sd.step = ST_DIG4;
            ST_DIG4:   sd.step = ST_DIG5;
            ST_DIG5:   sd.step = ST_CR2;
            ST_QUERY:  sd.step = ST_CR2;
            ST_CR2:    sd.step = ST_LF2;
            ST_LF2:    sd.step = ST_PROMPT;
            ST_PROMPT: sd.state = MS_RX_POLL;
            ST_ECHO: begin
              if (char_ok(sq.rx_char)) begin
                sd.state = MS_PUSH;
              end else begin
                sd.step = ST_QUERY;
              end
            end
            default:   sd.step = ST_CR1;
          endcase
        end
      end
      MS_RX_POLL: begin
        req.addr = RX_STATUS_ADDR;
        if (exit_in && !sq.issued) begin
          sd.state  = MS_RUN;
          sd.active = 1'b0;
        end else if (rsp.done && status_done) begin
          sd.state = MS_RX_READ;
        end
      end
      MS_RX_READ: begin
        req.addr = RX_BUFFER_ADDR;
        if (rsp.done) begin
          sd.rx_char = rsp.data[CHAR_W-1:0];
          sd.state   = MS_TX_POLL;
          sd.step    = ST_ECHO;
        end
      end
      MS_PUSH: begin
        // a full queue stalls polling, so no input is read and lost
        push = fifo_ready;
        if (fifo_ready) begin
          sd.state = MS_RX_POLL;
        end
      end
      default: sd.state = MS_RUN;
    endcase
    // issue once per bus state, rearm when the answer arrives
    req_valid = !sq.issued && (sq.state != MS_RUN) && (sq.state != MS_PUSH) &&
                !(sq.state == MS_RX_POLL && exit_in);
    if (req_valid) begin
      sd.issued = 1'b1;
    end
    if (rsp.done) begin
      sd.issued = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sq <= '0;
    end else begin
      sq <= sd;
    end
  end

  assign monitor_active_out = sq.active;

  // bus cycle engine
  cmn_bus_master u_bus (
    .clock_in      (clock_in),
    .arst_n_in     (arst_n_in),
    .req_valid_in  (req_valid),
    .req_in        (req),
    .rsp_out       (rsp),
    .bus_addr_out  (bus_addr_out),
    .bus_wdata_out (bus_wdata_out),
    .bus_rd_out    (bus_rd_out),
    .bus_wr_out    (bus_wr_out),
    .bus_rdata_in  (bus_rdata_in),
    .bus_ack_in    (bus_ack_in)
  );

  // accepted characters, parity bit removed
  cmn_fifo #(
    .WIDTH (CHAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .arst_n_in     (arst_n_in),
    .in_valid_in   (push),
    .in_data_in    (sq.rx_char & CH_MASK7),
    .in_ready_out  (fifo_ready),
    .out_valid_out (cmd_valid_out),
    .out_data_out  (cmd_char_out),
    .out_ready_in  (cmd_ready_in)
  );

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_tx_done;
    sq.state == MS_TX_WRITE && rsp.done;
  endsequence

  sequence s_prompt_sent;
    s_tx_done ##0 (sq.step == ST_PROMPT);
  endsequence

  a_entry_flush: assert property (
    sq.state == MS_RUN && entry_evt |=> sq.state == MS_FLUSH ##1 bus_rd_out &&
    bus_addr_out == RX_BUFFER_ADDR)
    else $error("entry did not start with a buffer read");
  a_flush_discard: assert property (
    sq.state == MS_FLUSH && rsp.done |=> sq.state == MS_TX_POLL && sq.step == ST_CR1 &&
    $stable(sq.rx_char))
    else $error("flushed character not discarded");
  a_digit_octal: assert property (
    bus_wr_out && sq.step >= ST_DIG0 && sq.step <= ST_DIG5 |->
    bus_wdata_out[7:3] == 5'h06)
    else $error("program counter digit not octal");
  a_digit_first: assert property (
    bus_wr_out && sq.step == ST_DIG0 |-> bus_wdata_out[7:0] == (CH_ZERO | {7'h00, sq.pc[15]}))
    else $error("top digit wrong");
  a_timeout_query: assert property (
    s_tx_done ##0 (sq.step == ST_LF1 && !sq.pc_mode) |=> sq.step == ST_QUERY)
    else $error("timeout entry did not print query");
  // an exit request in the first polling cycle legally skips the status read
  a_prompt_then_poll: assert property (
    s_prompt_sent |=> sq.state == MS_RX_POLL ##1 (sq.state == MS_RUN ||
    (bus_rd_out && bus_addr_out == RX_STATUS_ADDR)))
    else $error("no receive polling after prompt");
  a_rx_keep_poll: assert property (
    sq.state == MS_RX_POLL && rsp.done && !status_done && !exit_in |=>
    sq.state == MS_RX_POLL ##1 (bus_rd_out || sq.state == MS_RUN))
    else $error("receive polling stopped early");
  a_rx_fetch: assert property (
    sq.state == MS_RX_POLL && rsp.done && status_done && !exit_in |=>
    ##1 bus_rd_out && bus_addr_out == RX_BUFFER_ADDR)
    else $error("received character not fetched");
  // a busy transmitter must be asked again, never written blindly
  a_tx_keep_poll: assert property (
    sq.state == MS_TX_POLL && rsp.done && !status_done |=>
    sq.state == MS_TX_POLL ##1 bus_rd_out && bus_addr_out == TX_STATUS_ADDR)
    else $error("transmit polling stopped early");
  a_tx_read_write: assert property (
    sq.state == MS_TX_READ && rsp.done |=> ##1 bus_wr_out &&
    bus_addr_out == TX_BUFFER_ADDR)
    else $error("transmit buffer write missing");
  a_own_bit7_clear: assert property (
    bus_wr_out && sq.step != ST_ECHO |-> !bus_wdata_out[7] && bus_wdata_out[15:8] == 8'h00)
    else $error("generated character has bit 7 set");
  a_bad_char_query: assert property (
    s_tx_done ##0 (sq.step == ST_ECHO && !char_ok(sq.rx_char)) |=>
    sq.step == ST_QUERY && sq.state == MS_TX_POLL)
    else $error("invalid character not answered");
endmodule : cmn_console_monitor

/* logic/cmn_fifo.sv */
// command character queue with registered head
`timescale 1ns/1ps
module cmn_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             arst_n_in,
  // filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // draining side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               count;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } cmn_fifo_st_s;

  cmn_fifo_st_s fq, fd;
  logic         push;
  logic         pop_mem;

  // head register refills whenever it empties or is taken
  always_comb begin
    fd      = fq;
    push    = in_valid_in && (fq.count != CW'(DEPTH));
    pop_mem = (fq.count != '0) && (!fq.out_valid || out_ready_in);
    if (fq.out_valid && out_ready_in) begin
      fd.out_valid = 1'b0;
    end
    if (pop_mem) begin
      fd.out_data  = fq.mem[fq.rd];
      fd.out_valid = 1'b1;
      fd.rd        = fq.rd + 1'b1;
    end
    if (push) begin
      fd.mem[fq.wr] = in_data_in;
      fd.wr         = fq.wr + 1'b1;
    end
    if (push && !pop_mem) begin
      fd.count = fq.count + 1'b1;
    end else if (!push && pop_mem) begin
      fd.count = fq.count - 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fq <= '0;
    end else begin
      fq <= fd;
    end
  end

  assign in_ready_out  = (fq.count != CW'(DEPTH));
  assign out_valid_out = fq.out_valid;
  assign out_data_out  = fq.out_data;

  a_fifo_full_hold: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (fq.count == CW'(DEPTH)) && !out_ready_in |=> $stable(fq.wr))
    else $error("fifo written while full");
endmodule : cmn_fifo

/* logic/cmn_pkg.sv */
// shared constants and types for the console monitor sequencer
package cmn_pkg;

  // system bus shape
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CHAR_W = 8;

  // console serial interface register addresses
  localparam logic [ADDR_W-1:0] RX_STATUS_ADDR = 16'hff70;
  localparam logic [ADDR_W-1:0] RX_BUFFER_ADDR = 16'hff72;
  localparam logic [ADDR_W-1:0] TX_STATUS_ADDR = 16'hff74;
  localparam logic [ADDR_W-1:0] TX_BUFFER_ADDR = 16'hff76;

  // done flag position in both status registers
  localparam int DONE_BIT = 7;

  // depth of the command character queue
  localparam int CMD_FIFO_DEPTH = 32;

  // characters the monitor generates or accepts, and the parity mask
  localparam logic [CHAR_W-1:0] CH_CR     = 8'h0d;
  localparam logic [CHAR_W-1:0] CH_LF     = 8'h0a;
  localparam logic [CHAR_W-1:0] CH_QUERY  = 8'h3f;
  localparam logic [CHAR_W-1:0] CH_PROMPT = 8'h40;
  localparam logic [CHAR_W-1:0] CH_ZERO   = 8'h30;
  localparam logic [CHAR_W-1:0] CH_SEVEN  = 8'h37;
  localparam logic [CHAR_W-1:0] CH_SLASH  = 8'h2f;
  localparam logic [CHAR_W-1:0] CH_UP_D   = 8'h44;
  localparam logic [CHAR_W-1:0] CH_UP_G   = 8'h47;
  localparam logic [CHAR_W-1:0] CH_UP_P   = 8'h50;
  localparam logic [CHAR_W-1:0] CH_UP_R   = 8'h52;
  localparam logic [CHAR_W-1:0] CH_UP_S   = 8'h53;
  localparam logic [CHAR_W-1:0] CH_UP_X   = 8'h58;
  localparam logic [CHAR_W-1:0] CH_MASK7  = 8'h7f;

  // message steps of the announce and reply sequences
  typedef enum logic [3:0] {
    ST_CR1    = 4'h0,
    ST_LF1    = 4'h1,
    ST_DIG0   = 4'h2,
    ST_DIG1   = 4'h3,
    ST_DIG2   = 4'h4,
    ST_DIG3   = 4'h5,
    ST_DIG4   = 4'h6,
    ST_DIG5   = 4'h7,
    ST_CR2    = 4'h8,
    ST_LF2    = 4'h9,
    ST_PROMPT = 4'ha,
    ST_ECHO   = 4'hb,
    ST_QUERY  = 4'hc
  } cmn_step_e;

  // sequencer states
  typedef enum logic [3:0] {
    MS_RUN     = 4'h0,
    MS_FLUSH   = 4'h1,
    MS_TX_POLL = 4'h2,
    MS_TX_READ = 4'h3,
    MS_TX_WRITE= 4'h4,
    MS_RX_POLL = 4'h5,
    MS_RX_READ = 4'h6,
    MS_PUSH    = 4'h7
  } cmn_state_e;

  // bus cycle request and answer
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmn_bus_req_s;

  typedef struct packed {
    logic              done;
    logic [DATA_W-1:0] data;
  } cmn_bus_rsp_s;

endpackage : cmn_pkg

/* sim/cmn_console_model.sv */
// bus-side model of the console serial interface
`timescale 1ns/1ps
module cmn_console_model (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  // system bus
  input  wire logic [15:0] bus_addr_in,
  input  wire logic [15:0] bus_wdata_in,
  input  wire logic        bus_rd_in,
  input  wire logic        bus_wr_in,
  output logic [15:0]      bus_rdata_out,
  output logic             bus_ack_out,
  // bench side
  input  wire logic        slow_in,
  input  wire logic        rx_load_in,
  input  wire logic [7:0]  rx_char_in,
  output logic             rx_full_out,
  output logic             tx_stb_out,
  output logic [7:0]       tx_char_out
);
  import cmn_pkg::*;
  logic [7:0] rx_q;
  logic [2:0] wait_q;
  logic [2:0] busy_q;
  // one answer per strobe; a slow answer stretches the cycle
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {bus_ack_out, tx_stb_out, rx_full_out, wait_q, busy_q, rx_q, tx_char_out} <= '0;
      bus_rdata_out <= 16'h5a5a;
    end else begin
      bus_ack_out <= 1'b0;
      tx_stb_out <= 1'b0;
      bus_rdata_out <= ~bus_rdata_out; // released bus never shows a stale word
      if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
      if (rx_load_in) begin
        rx_full_out <= 1'b1;
        rx_q <= rx_char_in;
      end
      if ((bus_rd_in || bus_wr_in) && !bus_ack_out) begin
        wait_q <= wait_q + 3'h1;
        if (!slow_in || wait_q == 3'h5) begin
          wait_q <= 3'h0;
          bus_ack_out <= 1'b1;
          case (bus_addr_in)
            RX_STATUS_ADDR: bus_rdata_out <= {8'h00, rx_full_out, 7'h00};
            RX_BUFFER_ADDR: begin
              bus_rdata_out <= {8'h00, rx_q};
              if (bus_rd_in) rx_full_out <= 1'b0;
            end
            TX_STATUS_ADDR: bus_rdata_out <= {8'h00, busy_q == 3'h0, 7'h00};
            TX_BUFFER_ADDR: begin
              bus_rdata_out <= 16'h0000;
              if (bus_wr_in) begin
                tx_stb_out <= 1'b1;
                tx_char_out <= bus_wdata_in[7:0];
                busy_q <= 3'h4;
              end
            end
            default: bus_rdata_out <= 16'hffff;
          endcase
        end
      end
    end
  end
endmodule : cmn_console_model

/* sim/tb_top.sv */
// self-checking bench for the console monitor sequencer
`timescale 1ns/1ps
module tb_top;
  import cmn_pkg::*;
  localparam int FD = 4; // small queue so that it fills quickly
  logic clk = 1'b0, rst_n = 1'b0, exit_r = 1'b0, cmd_ready = 1'b0, fetch = 1'b0;
  logic slow = 1'b0, rx_load = 1'b0, rdy_en = 1'b1, chk_on = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [15:0] pc = 16'h0000, addr, wdata, rdata;
  logic [7:0] rx_char = 8'h00, tx_char, cmd_char;
  logic rd, wr, ack, rx_full, tx_stb, cmd_valid, active;
  logic [31:0] rnd = 32'h84c0;
  logic [7:0] txq[$], cq[$];
  int errors = 0, compares = 0;
  string s = "01234567RS/GPXDA9r@";

  always #50 clk = ~clk;

  cmn_console_monitor #(.FIFO_DEPTH(FD)) dut (.clock_in(clk), .arst_n_in(rst_n),
    .break_in(ev[0]), .halt_instr_in(ev[1]), .bus_halt_request_in(ev[2]), .nxm_in(ev[3]),
    .nxm_fetch_in(fetch), .pc_in(pc), .exit_in(exit_r), .bus_addr_out(addr),
    .bus_wdata_out(wdata), .bus_rd_out(rd), .bus_wr_out(wr), .bus_rdata_in(rdata),
    .bus_ack_in(ack), .cmd_char_out(cmd_char), .cmd_valid_out(cmd_valid),
    .cmd_ready_in(cmd_ready), .monitor_active_out(active));

  cmn_console_model model (.clock_in(clk), .arst_n_in(rst_n), .bus_addr_in(addr),
    .bus_wdata_in(wdata), .bus_rd_in(rd), .bus_wr_in(wr), .bus_rdata_out(rdata),
    .bus_ack_out(ack), .slow_in(slow), .rx_load_in(rx_load), .rx_char_in(rx_char),
    .rx_full_out(rx_full), .tx_stb_out(tx_stb), .tx_char_out(tx_char));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic bad(input string m);
    errors++;
    $display("BAD t=%0t %s", $time, m);
  endtask : bad

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) bad($sformatf("%s got %h expected %h", what, got, exp));
  endtask : cmp8

  task automatic drain(input logic all);
    int n;
    for (n = 0; n < 8000 && (txq.size() != 0 || (all && cq.size() != 0)); n++) @(negedge clk);
    if (n == 8000) bad("no progress");
  endtask : drain

  // banner expectation first, then the entry event itself
  task automatic enter(input int kind);
    logic [15:0] p;
    p = rnd[15:0];
    rx_char = rnd[23:16]; // stale input that must be thrown away
    rx_load = 1'b1;
    @(negedge clk);
    rx_load = 1'b0;
    txq.push_back(CH_CR);
    txq.push_back(CH_LF);
    if (kind == 4) txq.push_back(CH_QUERY);
    else begin
      txq.push_back(CH_ZERO + {7'h00, p[15]});
      for (int i = 4; i >= 0; i--) txq.push_back(CH_ZERO + {5'h00, p[i*3 +: 3]});
    end
    txq.push_back(CH_CR);
    txq.push_back(CH_LF);
    txq.push_back(CH_PROMPT);
    pc = p;
    fetch = (kind == 3);
    ev[kind > 3 ? 3 : kind] = 1'b1;
    repeat (4) @(negedge clk); // covers the halt line synchroniser
    ev = 4'h0;
    drain(1'b1);
    cmp8({7'h00, active}, 8'h01, "entry");
    cmp8({7'h00, rx_full}, 8'h00, "flush");
    $display("test entry %0d done", kind);
  endtask : enter

  task automatic leave();
    int n;
    repeat (2) @(negedge clk);
    exit_r = 1'b1;
    for (n = 0; n < 4000 && active !== 1'b0; n++) @(negedge clk);
    exit_r = 1'b0;
    cmp8({7'h00, active}, 8'h00, "exit");
  endtask : leave

  task automatic send(input logic [7:0] c, input logic acc);
    int n;
    for (n = 0; n < 4000 && rx_full; n++) @(negedge clk);
    txq.push_back(c);
    if (acc) cq.push_back(c & CH_MASK7);
    else begin
      txq.push_back(CH_QUERY);
      txq.push_back(CH_CR);
      txq.push_back(CH_LF);
      txq.push_back(CH_PROMPT);
    end
    rx_char = c;
    rx_load = 1'b1;
    @(negedge clk);
    rx_load = 1'b0;
  endtask : send

  // random ready and bus stretching, off the sampling edge
  always @(negedge clk) begin
    rnd = lfsr(rnd);
    cmd_ready = rdy_en & rnd[3];
    slow = rnd[9];
  end

  // each result is matched against the oldest note
  always @(posedge clk) begin
    if (tx_stb === 1'b1 && chk_on) begin
      if (txq.size() == 0) bad("unexpected character");
      else cmp8(tx_char, txq.pop_front(), "tx");
    end
    if (cmd_valid === 1'b1 && cmd_ready) begin
      if (cq.size() == 0) bad("unexpected command");
      else cmp8(cmd_char, cq.pop_front(), "cmd");
    end
  end

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (60000) @(posedge clk);
    bad("watchdog");
    end_of_test();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    leave(); // power-up banner is not compared
    chk_on = 1'b1;
    enter(0);
    for (int k = 0; k < 19; k++) send(s[k] | {rnd[5], 7'h00}, k < 15);
    send(CH_CR | {rnd[6], 7'h00}, 1'b1);
    send(CH_LF, 1'b1);
    drain(1'b1);
    $display("test characters done");
    // full queue must stop receive polling
    rdy_en = 1'b0;
    // queue holds its depth plus the head; one more waits in the sequencer
    for (int k = 0; k <= FD + 1; k++) send(CH_ZERO + 8'(k), 1'b1);
    drain(1'b0);
    send(CH_SEVEN, 1'b1);
    repeat (300) @(negedge clk);
    cmp8({7'h00, rx_full}, 8'h01, "stall");
    rdy_en = 1'b1;
    drain(1'b1);
    $display("test fill done");
    for (int k = 1; k < 5; k++) begin
      leave();
      enter(k);
    end
    end_of_test();
  end
endmodule : tb_top
